/* psa_simd_alu.sv */
`timescale 1ns/1ps
module psa_simd_alu (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  input  wire logic        OP_VALID_I,
  input  wire logic [5:0]  OP_CODE_I,
  input  wire logic [63:0] SRC_A_I,
  input  wire logic [63:0] SRC_B_I,
  output logic [63:0]      RESULT_O,
  output logic             RESULT_VALID_O,
  output logic             OP_ILLEGAL_O,
  output logic [31:0]      FEATURE_FLAGS_O
);

  psa_pkg::psa_state_t state_reg;
  psa_pkg::psa_state_t state_next;
  psa_pkg::psa_op_t    op;
  psa_pkg::psa_size_t  add_size;
  psa_pkg::psa_sat_t   add_sat;
  logic                add_sub;
  logic [63:0]         add_res;
  logic [63:0]         mul_hi;
  logic [63:0]         mul_lo;
  logic [63:0]         mul_pair;
  logic [63:0]         eq_b, eq_w, eq_d, gt_b, gt_w, gt_d;
  logic [63:0]         sll_w, sll_d, srl_w, srl_d, sra_w, sra_d;
  logic [63:0]         sll_q, srl_q;
  logic [63:0]         pk_sb, pk_sw, pk_ub;
  logic [63:0]         up_hb, up_hw, up_hd, up_lb, up_lw, up_ld;
  logic                big_w, big_d, big_q;
  logic signed [31:0]  chk_prod0;

  assign op = psa_pkg::psa_op_t'(OP_CODE_I);

  // narrowing helpers for the pack group
  function automatic logic [7:0] sat_w_sb(input logic [15:0] w);
    if ($signed(w) > $signed({{8{1'b0}}, psa_pkg::SB_MAX})) begin
      sat_w_sb = psa_pkg::SB_MAX;
    end else if ($signed(w) < $signed({{8{1'b1}}, psa_pkg::SB_MIN})) begin
      sat_w_sb = psa_pkg::SB_MIN;
    end else begin
      sat_w_sb = w[7:0];
    end
  endfunction

  function automatic logic [7:0] sat_w_ub(input logic [15:0] w);
    if (w[15]) begin
      sat_w_ub = psa_pkg::UB_MIN;
    end else if (w[14:8] != 7'h0) begin
      sat_w_ub = psa_pkg::UB_MAX;
    end else begin
      sat_w_ub = w[7:0];
    end
  endfunction

  function automatic logic [15:0] sat_d_sw(input logic [31:0] d);
    if ($signed(d) > $signed({{16{1'b0}}, psa_pkg::SW_MAX})) begin
      sat_d_sw = psa_pkg::SW_MAX;
    end else if ($signed(d) < $signed({{16{1'b1}}, psa_pkg::SW_MIN})) begin
      sat_d_sw = psa_pkg::SW_MIN;
    end else begin
      sat_d_sw = d[15:0];
    end
  endfunction

  // adder policy per operation; dword lanes never saturate
  always_comb begin
    add_sub  = 1'b0;
    add_size = psa_pkg::SZ_BYTE;
    add_sat  = psa_pkg::SAT_WRAP;
    unique case (op)
      psa_pkg::OP_ADD_W_WRAP, psa_pkg::OP_ADD_W_SSAT, psa_pkg::OP_ADD_W_USAT: add_size = psa_pkg::SZ_WORD;
      psa_pkg::OP_ADD_D_WRAP: add_size = psa_pkg::SZ_DWORD;
      psa_pkg::OP_SUB_B_WRAP, psa_pkg::OP_SUB_B_SSAT, psa_pkg::OP_SUB_B_USAT: add_sub = 1'b1;
      psa_pkg::OP_SUB_W_WRAP, psa_pkg::OP_SUB_W_SSAT, psa_pkg::OP_SUB_W_USAT: begin
        add_sub  = 1'b1;
        add_size = psa_pkg::SZ_WORD;
      end
      psa_pkg::OP_SUB_D_WRAP: begin
        add_sub  = 1'b1;
        add_size = psa_pkg::SZ_DWORD;
      end
      default: add_sub = 1'b0;
    endcase
    if (op inside {psa_pkg::OP_ADD_B_SSAT, psa_pkg::OP_ADD_W_SSAT, psa_pkg::OP_SUB_B_SSAT,
                   psa_pkg::OP_SUB_W_SSAT}) begin
      add_sat = psa_pkg::SAT_SIGNED;
    end else if (op inside {psa_pkg::OP_ADD_B_USAT, psa_pkg::OP_ADD_W_USAT, psa_pkg::OP_SUB_B_USAT,
                            psa_pkg::OP_SUB_W_USAT}) begin
      add_sat = psa_pkg::SAT_UNSIGNED;
    end
  end

  psa_lane_addsub u_addsub (
    .a_i     (SRC_A_I),
    .b_i     (SRC_B_I),
    .sub_i   (add_sub),
    .esize_i (add_size),
    .sat_i   (add_sat),
    .sum_o   (add_res)
  );

  // byte lanes: compare, unpack and unsigned/signed word narrowing
  for (genvar i = 0; i < 8; i++) begin : g_b
    assign eq_b[8*i+:8] = (SRC_A_I[8*i+:8] == SRC_B_I[8*i+:8]) ? psa_pkg::UB_MAX : psa_pkg::UB_MIN;
    assign gt_b[8*i+:8] = ($signed(SRC_A_I[8*i+:8]) > $signed(SRC_B_I[8*i+:8])) ? psa_pkg::UB_MAX
                                                                                : psa_pkg::UB_MIN;
    assign up_lb[8*i+:8] = (i % 2 == 0) ? SRC_A_I[8*(i/2)+:8] : SRC_B_I[8*(i/2)+:8];
    assign up_hb[8*i+:8] = (i % 2 == 0) ? SRC_A_I[8*(i/2)+32+:8] : SRC_B_I[8*(i/2)+32+:8];
    // low half narrows the destination operand, high half the source
    assign pk_sb[8*i+:8] = sat_w_sb((i < 4) ? SRC_A_I[16*(i%4)+:16] : SRC_B_I[16*(i%4)+:16]);
    assign pk_ub[8*i+:8] = sat_w_ub((i < 4) ? SRC_A_I[16*(i%4)+:16] : SRC_B_I[16*(i%4)+:16]);
  end

  // word lanes: multiply, compare, shifts, unpack, dword narrowing
  assign big_w = (SRC_B_I > 64'hf);
  for (genvar i = 0; i < 4; i++) begin : g_w
    logic signed [31:0] prod;
    assign prod = $signed(SRC_A_I[16*i+:16]) * $signed(SRC_B_I[16*i+:16]);
    assign mul_hi[16*i+:16] = prod[31:16];
    assign mul_lo[16*i+:16] = prod[15:0];
    assign eq_w[16*i+:16] = (SRC_A_I[16*i+:16] == SRC_B_I[16*i+:16]) ? psa_pkg::UW_MAX : psa_pkg::UW_MIN;
    assign gt_w[16*i+:16] = ($signed(SRC_A_I[16*i+:16]) > $signed(SRC_B_I[16*i+:16])) ? psa_pkg::UW_MAX
                                                                                    : psa_pkg::UW_MIN;
    assign sll_w[16*i+:16] = big_w ? 16'h0 : SRC_A_I[16*i+:16] << SRC_B_I[3:0];
    assign srl_w[16*i+:16] = big_w ? 16'h0 : SRC_A_I[16*i+:16] >> SRC_B_I[3:0];
    // counts past the width leave nothing but the sign
    assign sra_w[16*i+:16] = $signed(SRC_A_I[16*i+:16]) >>> (big_w ? 4'hf : SRC_B_I[3:0]);
    assign up_lw[16*i+:16] = (i % 2 == 0) ? SRC_A_I[16*(i/2)+:16] : SRC_B_I[16*(i/2)+:16];
    assign up_hw[16*i+:16] = (i % 2 == 0) ? SRC_A_I[16*(i/2)+32+:16] : SRC_B_I[16*(i/2)+32+:16];
    assign pk_sw[16*i+:16] = sat_d_sw((i < 2) ? SRC_A_I[32*(i%2)+:32] : SRC_B_I[32*(i%2)+:32]);
  end
  assign chk_prod0 = $signed(SRC_A_I[15:0]) * $signed(SRC_B_I[15:0]);

  // dword lanes: pair sums, compare, shifts
  assign big_d = (SRC_B_I > 64'h1f);
  for (genvar i = 0; i < 2; i++) begin : g_d
    assign mul_pair[32*i+:32] = g_w[2*i].prod + g_w[2*i+1].prod;
    assign eq_d[32*i+:32] = (SRC_A_I[32*i+:32] == SRC_B_I[32*i+:32]) ? 32'hffff_ffff : 32'h0;
    assign gt_d[32*i+:32] = ($signed(SRC_A_I[32*i+:32]) > $signed(SRC_B_I[32*i+:32])) ? 32'hffff_ffff
                                                                                    : 32'h0;
    assign sll_d[32*i+:32] = big_d ? 32'h0 : SRC_A_I[32*i+:32] << SRC_B_I[4:0];
    assign srl_d[32*i+:32] = big_d ? 32'h0 : SRC_A_I[32*i+:32] >> SRC_B_I[4:0];
    assign sra_d[32*i+:32] = $signed(SRC_A_I[32*i+:32]) >>> (big_d ? 5'h1f : SRC_B_I[4:0]);
  end
  assign up_ld = {SRC_B_I[31:0], SRC_A_I[31:0]};
  assign up_hd = {SRC_B_I[63:32], SRC_A_I[63:32]};

  // quadword shifts
  assign big_q = (SRC_B_I > 64'h3f);
  assign sll_q = big_q ? 64'h0 : SRC_A_I << SRC_B_I[5:0];
  assign srl_q = big_q ? 64'h0 : SRC_A_I >> SRC_B_I[5:0];

  // result select; the destination value changes along with the valid and illegal bits, no other status flag
  always_comb begin
    state_next         = state_reg;
    state_next.valid   = 1'b0;
    state_next.illegal = 1'b0;
    if (OP_VALID_I) begin
      state_next.valid = 1'b1;
      unique case (op)
        psa_pkg::OP_ADD_B_WRAP, psa_pkg::OP_ADD_W_WRAP, psa_pkg::OP_ADD_D_WRAP,
        psa_pkg::OP_SUB_B_WRAP, psa_pkg::OP_SUB_W_WRAP, psa_pkg::OP_SUB_D_WRAP,
        psa_pkg::OP_ADD_B_SSAT, psa_pkg::OP_ADD_W_SSAT, psa_pkg::OP_SUB_B_SSAT,
        psa_pkg::OP_SUB_W_SSAT, psa_pkg::OP_ADD_B_USAT, psa_pkg::OP_ADD_W_USAT,
        psa_pkg::OP_SUB_B_USAT, psa_pkg::OP_SUB_W_USAT: state_next.result = add_res;
        psa_pkg::OP_MUL_HIGH:    state_next.result = mul_hi;
        psa_pkg::OP_MUL_LOW:     state_next.result = mul_lo;
        psa_pkg::OP_MUL_PAIRSUM: state_next.result = mul_pair;
        psa_pkg::OP_CMP_EQ_B:    state_next.result = eq_b;
        psa_pkg::OP_CMP_EQ_W:    state_next.result = eq_w;
        psa_pkg::OP_CMP_EQ_D:    state_next.result = eq_d;
        psa_pkg::OP_CMP_GT_B:    state_next.result = gt_b;
        psa_pkg::OP_CMP_GT_W:    state_next.result = gt_w;
        psa_pkg::OP_CMP_GT_D:    state_next.result = gt_d;
        psa_pkg::OP_NARROW_W_SB: state_next.result = pk_sb;
        psa_pkg::OP_NARROW_D_SW: state_next.result = pk_sw;
        psa_pkg::OP_NARROW_W_UB: state_next.result = pk_ub;
        psa_pkg::OP_UNPK_HI_B:   state_next.result = up_hb;
        psa_pkg::OP_UNPK_HI_W:   state_next.result = up_hw;
        psa_pkg::OP_UNPK_HI_D:   state_next.result = up_hd;
        psa_pkg::OP_UNPK_LO_B:   state_next.result = up_lb;
        psa_pkg::OP_UNPK_LO_W:   state_next.result = up_lw;
        psa_pkg::OP_UNPK_LO_D:   state_next.result = up_ld;
        psa_pkg::OP_AND:         state_next.result = SRC_A_I & SRC_B_I;
        psa_pkg::OP_AND_NOT:     state_next.result = ~SRC_A_I & SRC_B_I;
        psa_pkg::OP_OR:          state_next.result = SRC_A_I | SRC_B_I;
        psa_pkg::OP_XOR:         state_next.result = SRC_A_I ^ SRC_B_I;
        psa_pkg::OP_SLL_W:       state_next.result = sll_w;
        psa_pkg::OP_SLL_D:       state_next.result = sll_d;
        psa_pkg::OP_SLL_Q:       state_next.result = sll_q;
        psa_pkg::OP_SRL_W:       state_next.result = srl_w;
        psa_pkg::OP_SRL_D:       state_next.result = srl_d;
        psa_pkg::OP_SRL_Q:       state_next.result = srl_q;
        psa_pkg::OP_SRA_W:       state_next.result = sra_w;
        psa_pkg::OP_SRA_D:       state_next.result = sra_d;
        // loads zero-extend; stores and register reads take the low word
        psa_pkg::OP_MOVE_32:     state_next.result = {32'h0, SRC_B_I[31:0]};
        psa_pkg::OP_MOVE_64:     state_next.result = SRC_B_I;
        psa_pkg::OP_EMPTY_STATE: state_next.result = state_reg.result;
        default: begin
          // undefined code: flagged to the decoder, result left alone
          state_next.valid   = 1'b0;
          state_next.illegal = 1'b1;
        end
      endcase
    end
  end

  // all state in one register, synchronous reset
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      state_reg <= '{result: psa_pkg::RESULT_RESET, valid: 1'b0, illegal: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign RESULT_O        = state_reg.result;
  assign RESULT_VALID_O  = state_reg.valid;
  assign OP_ILLEGAL_O    = state_reg.illegal;
  assign FEATURE_FLAGS_O = psa_pkg::FEATURE_FLAGS;

  a_wrap_byte_add: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_ADD_B_WRAP)
    |=> RESULT_O[7:0] == 8'($past(SRC_A_I[7:0]) + $past(SRC_B_I[7:0])))
    else $error("byte wraparound add wrong");

  a_sat_sbyte_high: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_ADD_B_SSAT
     && ($signed(SRC_A_I[7:0]) + $signed(SRC_B_I[7:0])) > 127)
    |=> RESULT_O[7:0] == psa_pkg::SB_MAX)
    else $error("signed byte positive clamp wrong");

  a_sat_sword_low: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_SUB_W_SSAT
     && ($signed(SRC_A_I[15:0]) - $signed(SRC_B_I[15:0])) < -32768)
    |=> RESULT_O[15:0] == psa_pkg::SW_MIN)
    else $error("signed word negative clamp wrong");

  a_sat_ubyte_low: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_SUB_B_USAT && SRC_A_I[7:0] < SRC_B_I[7:0])
    |=> RESULT_O[7:0] == psa_pkg::UB_MIN)
    else $error("unsigned byte floor wrong");

  a_sat_uword_high: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_ADD_W_USAT
     && ({1'b0, SRC_A_I[63:48]} + {1'b0, SRC_B_I[63:48]}) > {1'b0, psa_pkg::UW_MAX})
    |=> RESULT_O[63:48] == psa_pkg::UW_MAX)
    else $error("unsigned word ceiling wrong");

  a_mul_high_half: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_MUL_HIGH) |=> RESULT_O[15:0] == $past(chk_prod0[31:16]))
    else $error("high product half wrong");

  a_lane_no_carry: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_ADD_B_WRAP && SRC_A_I[7:0] == 8'hff && SRC_B_I[7:0] == 8'h01)
    |=> RESULT_O[15:8] == 8'($past(SRC_A_I[15:8]) + $past(SRC_B_I[15:8])))
    else $error("carry leaked into next byte");

  a_cmp_eq_mask: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_CMP_EQ_B)
    |=> RESULT_O[7:0] == (($past(SRC_A_I[7:0]) == $past(SRC_B_I[7:0])) ? psa_pkg::UB_MAX : psa_pkg::UB_MIN))
    else $error("equal mask wrong");

  a_shift_zero_fill: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I == psa_pkg::OP_SRL_W && SRC_B_I > 64'hf) |=> RESULT_O == 64'h0)
    else $error("over-long logical shift not zero");

  a_illegal_code: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (OP_VALID_I && OP_CODE_I >= psa_pkg::OP_COUNT) |=> OP_ILLEGAL_O && !RESULT_VALID_O && $stable(RESULT_O))
    else $error("undefined code not refused");

  a_feature_bit: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    FEATURE_FLAGS_O[psa_pkg::FEATURE_BIT])
    else $error("packed feature bit not reported");

endmodule

/* psa_pkg.sv */
package psa_pkg;

  // operation codes of the packed unit; codes from 6'h2f upward are undefined
  typedef enum logic [5:0] {
    OP_ADD_B_WRAP  = 6'h00, OP_ADD_W_WRAP  = 6'h01, OP_ADD_D_WRAP  = 6'h02,
    OP_SUB_B_WRAP  = 6'h03, OP_SUB_W_WRAP  = 6'h04, OP_SUB_D_WRAP  = 6'h05,
    OP_ADD_B_SSAT  = 6'h06, OP_ADD_W_SSAT  = 6'h07, OP_SUB_B_SSAT  = 6'h08,
    OP_SUB_W_SSAT  = 6'h09, OP_ADD_B_USAT  = 6'h0a, OP_ADD_W_USAT  = 6'h0b,
    OP_SUB_B_USAT  = 6'h0c, OP_SUB_W_USAT  = 6'h0d, OP_MUL_HIGH    = 6'h0e,
    OP_MUL_LOW     = 6'h0f, OP_MUL_PAIRSUM = 6'h10, OP_CMP_EQ_B    = 6'h11,
    OP_CMP_EQ_W    = 6'h12, OP_CMP_EQ_D    = 6'h13, OP_CMP_GT_B    = 6'h14,
    OP_CMP_GT_W    = 6'h15, OP_CMP_GT_D    = 6'h16, OP_NARROW_W_SB = 6'h17,
    OP_NARROW_D_SW = 6'h18, OP_NARROW_W_UB = 6'h19, OP_UNPK_HI_B   = 6'h1a,
    OP_UNPK_HI_W   = 6'h1b, OP_UNPK_HI_D   = 6'h1c, OP_UNPK_LO_B   = 6'h1d,
    OP_UNPK_LO_W   = 6'h1e, OP_UNPK_LO_D   = 6'h1f, OP_AND         = 6'h20,
    OP_AND_NOT     = 6'h21, OP_OR          = 6'h22, OP_XOR         = 6'h23,
    OP_SLL_W       = 6'h24, OP_SLL_D       = 6'h25, OP_SLL_Q       = 6'h26,
    OP_SRL_W       = 6'h27, OP_SRL_D       = 6'h28, OP_SRL_Q       = 6'h29,
    OP_SRA_W       = 6'h2a, OP_SRA_D       = 6'h2b, OP_MOVE_32     = 6'h2c,
    OP_MOVE_64     = 6'h2d, OP_EMPTY_STATE = 6'h2e
  } psa_op_t;

  localparam logic [5:0] OP_COUNT = 6'h2f;

  // element size and overflow policy for the lane adder
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2} psa_size_t;
  typedef enum logic [1:0] {SAT_WRAP = 2'h0, SAT_SIGNED = 2'h1, SAT_UNSIGNED = 2'h2} psa_sat_t;

  // saturation limits
  localparam logic [7:0]  SB_MAX = 8'h7f;
  localparam logic [7:0]  SB_MIN = 8'h80;
  localparam logic [15:0] SW_MAX = 16'h7fff;
  localparam logic [15:0] SW_MIN = 16'h8000;
  localparam logic [7:0]  UB_MAX = 8'hff;
  localparam logic [7:0]  UB_MIN = 8'h00;
  localparam logic [15:0] UW_MAX = 16'hffff;
  localparam logic [15:0] UW_MIN = 16'h0000;

  // feature identification word and the packed-integer bit in it
  localparam int          FEATURE_BIT   = 23;
  localparam logic [31:0] FEATURE_FLAGS = 32'h0080_0000;

  // reset value of the registered result output
  localparam logic [63:0] RESULT_RESET = 64'h0;

  typedef struct packed {
    logic [63:0] result;
    logic        valid;
    logic        illegal;
  } psa_state_t;

endpackage

/* psa_lane_addsub.sv */
`timescale 1ns/1ps
// lane adder: byte and word lanes have their own headroom bits and dword lanes drop the carry, so nothing crosses a lane edge
module psa_lane_addsub (
  input  wire logic [63:0]        a_i,
  input  wire logic [63:0]        b_i,
  input  wire logic               sub_i,
  input  wire psa_pkg::psa_size_t esize_i,
  input  wire psa_pkg::psa_sat_t  sat_i,
  output logic [63:0]             sum_o
);

  logic [63:0] byte_res;
  logic [63:0] word_res;
  logic [63:0] dword_res;
  logic        uns;

  assign uns = (sat_i == psa_pkg::SAT_UNSIGNED);

  // byte lanes, two guard bits keep the true result in range
  for (genvar i = 0; i < 8; i++) begin : g_byte
    logic [9:0] ea;
    logic [9:0] eb;
    logic [9:0] s;
    logic [7:0] r;
    assign ea = uns ? {2'h0, a_i[8*i+:8]} : {{2{a_i[8*i+7]}}, a_i[8*i+:8]};
    assign eb = uns ? {2'h0, b_i[8*i+:8]} : {{2{b_i[8*i+7]}}, b_i[8*i+:8]};
    assign s  = sub_i ? ea - eb : ea + eb;
    always_comb begin
      r = s[7:0];
      if (sat_i == psa_pkg::SAT_SIGNED && s[9:7] != 3'h0 && s[9:7] != 3'h7) begin
        r = s[9] ? psa_pkg::SB_MIN : psa_pkg::SB_MAX;
      end else if (uns && s[9]) begin
        r = psa_pkg::UB_MIN;
      end else if (uns && s[8]) begin
        r = psa_pkg::UB_MAX;
      end
    end
    assign byte_res[8*i+:8] = r;
  end

  // word lanes, same scheme at sixteen bits
  for (genvar i = 0; i < 4; i++) begin : g_word
    logic [17:0] ea;
    logic [17:0] eb;
    logic [17:0] s;
    logic [15:0] r;
    assign ea = uns ? {2'h0, a_i[16*i+:16]} : {{2{a_i[16*i+15]}}, a_i[16*i+:16]};
    assign eb = uns ? {2'h0, b_i[16*i+:16]} : {{2{b_i[16*i+15]}}, b_i[16*i+:16]};
    assign s  = sub_i ? ea - eb : ea + eb;
    always_comb begin
      r = s[15:0];
      if (sat_i == psa_pkg::SAT_SIGNED && s[17:15] != 3'h0 && s[17:15] != 3'h7) begin
        r = s[17] ? psa_pkg::SW_MIN : psa_pkg::SW_MAX;
      end else if (uns && s[17]) begin
        r = psa_pkg::UW_MIN;
      end else if (uns && s[16]) begin
        r = psa_pkg::UW_MAX;
      end
    end
    assign word_res[16*i+:16] = r;
  end

  // doubleword lanes only wrap, so the carry is simply dropped
  for (genvar i = 0; i < 2; i++) begin : g_dword
    assign dword_res[32*i+:32] = sub_i ? a_i[32*i+:32] - b_i[32*i+:32]
                                       : a_i[32*i+:32] + b_i[32*i+:32];
  end

  always_comb begin
    unique case (esize_i)
      psa_pkg::SZ_BYTE:  sum_o = byte_res;
      psa_pkg::SZ_WORD:  sum_o = word_res;
      psa_pkg::SZ_DWORD: sum_o = dword_res;
      default:           sum_o = dword_res;
    endcase
  end

endmodule

/* psa_issue_model.sv */
`timescale 1ns/1ps
// decode side: issues one operation and picks up what the unit answers
module psa_issue_model (
  input  wire logic        clk_i,
  input  wire logic [63:0] result_i,
  input  wire logic        result_valid_i,
  input  wire logic        op_illegal_i,
  output logic             op_valid_o,
  output logic [5:0]       op_code_o,
  output logic [63:0]      src_a_o,
  output logic [63:0]      src_b_o
);
  initial begin
    op_valid_o = 1'b0;
    op_code_o  = 6'h00;
    src_a_o    = 64'h0;
    src_b_o    = 64'h0;
  end

  // operands are inverted once released, so a stale value never looks right
  task automatic issue(input logic [5:0] code, input logic [63:0] a, input logic [63:0] b,
                       output logic [63:0] res, output logic [1:0] flags);
    @(negedge clk_i);
    op_valid_o = 1'b1;
    op_code_o  = code;
    src_a_o    = a;
    src_b_o    = b;
    @(negedge clk_i); // the answer pulse stands for the cycle after the taking edge
    res        = result_i;
    flags      = {result_valid_i, op_illegal_i};
    op_valid_o = 1'b0;
    op_code_o  = ~code;
    src_a_o    = ~a;
    src_b_o    = ~b;
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys;
  logic        reset;
  logic        op_valid;
  logic [5:0]  op_code;
  logic [63:0] src_a;
  logic [63:0] src_b;
  logic [63:0] result;
  logic        result_valid;
  logic        op_illegal;
  logic [31:0] feature_flags;
  int          fail_count;
  int          samples_checked;
  logic [63:0] last;

  psa_simd_alu dut (.CLK_SYS_I(clk_sys), .RESET_I(reset), .OP_VALID_I(op_valid), .OP_CODE_I(op_code),
    .SRC_A_I(src_a), .SRC_B_I(src_b), .RESULT_O(result), .RESULT_VALID_O(result_valid),
    .OP_ILLEGAL_O(op_illegal), .FEATURE_FLAGS_O(feature_flags));
  psa_issue_model host (.clk_i(clk_sys), .result_i(result), .result_valid_i(result_valid),
    .op_illegal_i(op_illegal), .op_valid_o(op_valid), .op_code_o(op_code), .src_a_o(src_a), .src_b_o(src_b));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      fail_count++;
    end
  endtask

  // one operation: a valid pulse without the refusal pulse, then the value
  task automatic run(input logic [5:0] code, input logic [63:0] a, input logic [63:0] b, input logic [63:0] exp);
    logic [63:0] r;
    logic [1:0]  f;
    host.issue(code, a, b, r, f);
    chk(64'h2, {62'h0, f});
    chk(exp, r);
    last = exp;
  endtask

  task automatic t_wrap();
    run(psa_pkg::OP_ADD_B_WRAP, 64'h01ff, 64'h0001, 64'h0100);
    run(psa_pkg::OP_SUB_D_WRAP, 64'h0, 64'h1, 64'h0000_0000_ffff_ffff);
    run(psa_pkg::OP_SUB_B_WRAP, 64'h0100, 64'h0001, 64'h01ff);
    run(psa_pkg::OP_ADD_W_WRAP, 64'h0001_ffff, 64'h0000_0001, 64'h0001_0000);
    run(psa_pkg::OP_ADD_D_WRAP, 64'h0000_0005_ffff_ffff, 64'h1, 64'h0000_0005_0000_0000);
    $display("test wrap done");
  endtask

  task automatic t_sat();
    run(psa_pkg::OP_ADD_B_SSAT, 64'h807f, 64'hff01, 64'h807f);
    run(psa_pkg::OP_SUB_B_SSAT, 64'h0080, 64'h0001, 64'h0080);
    run(psa_pkg::OP_SUB_W_SSAT, 64'h7fff_8000, 64'hffff_0001, 64'h7fff_8000);
    run(psa_pkg::OP_ADD_B_USAT, 64'h00ff, 64'h0001, 64'h00ff);
    run(psa_pkg::OP_SUB_B_USAT, 64'h0510, 64'h0120, 64'h0400);
    run(psa_pkg::OP_ADD_W_USAT, 64'hffff_0000_0000_ffff, 64'h0001_0000_0000_0001, 64'hffff_0000_0000_ffff);
    run(psa_pkg::OP_SUB_W_USAT, 64'h0005, 64'h0010, 64'h0000);
    $display("test saturation done");
  endtask

  task automatic t_mul_move();
    run(psa_pkg::OP_MUL_HIGH, 64'hffff_8000, 64'h0002_8000, 64'hffff_4000);
    run(psa_pkg::OP_MUL_LOW, 64'hffff_8000, 64'h0002_8000, 64'hfffe_0000);
    run(psa_pkg::OP_MUL_PAIRSUM, 64'hffff_8000, 64'h0002_8000, 64'h3fff_fffe);
    run(psa_pkg::OP_MOVE_32, 64'h0, 64'h1234_5678_9abc_def0, 64'h9abc_def0);
    run(psa_pkg::OP_MOVE_64, 64'h0, 64'h1234_5678_9abc_def0, 64'h1234_5678_9abc_def0);
    $display("test multiply and move done");
  endtask

  task automatic t_misc();
    run(psa_pkg::OP_AND_NOT, 64'hff00_ff00_ff00_ff00, 64'hffff_0000_ffff_0000, 64'h00ff_0000_00ff_0000);
    run(psa_pkg::OP_CMP_GT_B, 64'h8001, 64'h7fff, 64'h00ff);
    run(psa_pkg::OP_CMP_EQ_B, 64'h8001, 64'h7fff, 64'hffff_ffff_ffff_0000);
    run(psa_pkg::OP_SLL_W, 64'h8001, 64'h1, 64'h0002);
    run(psa_pkg::OP_SRL_W, 64'h8000_0000_0000_0001, 64'h1, 64'h4000_0000_0000_0000);
    run(psa_pkg::OP_SRA_W, 64'h8000_0000_0000_0001, 64'h1, 64'hc000_0000_0000_0000);
    run(psa_pkg::OP_NARROW_W_UB, 64'h0000_007f_ffff_0100, 64'h0, 64'h007f_00ff);
    run(psa_pkg::OP_NARROW_W_SB, 64'h0000_007f_ffff_0100, 64'h0, 64'h007f_ff7f);
    run(psa_pkg::OP_NARROW_D_SW, 64'h8000_0000_0001_0000, 64'h1234, 64'h0000_1234_8000_7fff);
    run(psa_pkg::OP_CMP_GT_W, 64'h0001_8000, 64'h0000_7fff, 64'h0000_0000_ffff_0000);
    run(psa_pkg::OP_CMP_EQ_D, 64'h0000_0001_0000_0000, 64'h0, 64'h0000_0000_ffff_ffff);
    run(psa_pkg::OP_SRL_W, 64'hffff_ffff_ffff_ffff, 64'h10, 64'h0);
    run(psa_pkg::OP_SRA_D, 64'h8000_0000_0000_0010, 64'h40, 64'hffff_ffff_0000_0000);
    run(psa_pkg::OP_SLL_Q, 64'h1, 64'h3f, 64'h8000_0000_0000_0000);
    run(psa_pkg::OP_SRL_Q, 64'h8000_0000_0000_0000, 64'h40, 64'h0);
    run(psa_pkg::OP_AND, 64'hf0f0, 64'hff00, 64'hf000);
    run(psa_pkg::OP_XOR, 64'hf0f0, 64'hff00, 64'h0ff0);
    run(psa_pkg::OP_OR, 64'h00f0, 64'h000f, 64'h00ff);
    $display("test logic shift compare pack done");
  endtask

  // upper halves are poisoned for the byte and word low forms and lower halves for the byte and word high forms; the dword forms use plain operands
  task automatic t_unpack();
    run(psa_pkg::OP_UNPK_LO_B, 64'hffff_ffff_0302_0100, 64'heeee_eeee_1312_1110, 64'h1303_1202_1101_1000);
    run(psa_pkg::OP_UNPK_HI_B, 64'h0706_0504_ffff_ffff, 64'h1716_1514_eeee_eeee, 64'h1707_1606_1505_1404);
    run(psa_pkg::OP_UNPK_LO_W, 64'hffff_ffff_0302_0100, 64'heeee_eeee_1312_1110, 64'h1312_0302_1110_0100);
    run(psa_pkg::OP_UNPK_HI_W, 64'h0302_0100_ffff_ffff, 64'h1312_1110_eeee_eeee, 64'h1312_0302_1110_0100);
    run(psa_pkg::OP_UNPK_LO_D, 64'h1111_1111_2222_2222, 64'h3333_3333_4444_4444, 64'h4444_4444_2222_2222);
    run(psa_pkg::OP_UNPK_HI_D, 64'h1111_1111_2222_2222, 64'h3333_3333_4444_4444, 64'h3333_3333_1111_1111);
    $display("test unpack done");
  endtask

  // undefined codes are refused, the state-emptying code leaves the result alone
  task automatic t_codes();
    logic [63:0] r;
    logic [1:0]  f;
    chk(64'h0080_0000, {32'h0, feature_flags});
    host.issue(6'h30, 64'h5, 64'h5, r, f);
    chk(64'h1, {62'h0, f});
    chk(last, r);
    host.issue(psa_pkg::OP_EMPTY_STATE, 64'h5, 64'h5, r, f);
    chk(64'h2, {62'h0, f});
    chk(last, r);
    for (int i = 0; i < 64; i++) begin
      host.issue(i[5:0], 64'h0, 64'h0, r, f);
      chk((i < 47) ? 64'h2 : 64'h1, {62'h0, f});
    end
    $display("test codes done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // watchdog: a hung run counts as a mismatch
  initial begin
    #400000;
    fail_count++;
    results();
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    last = 64'h0;
    reset = 1'b1;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    chk(64'h0, result);
    chk(64'h0, {62'h0, result_valid, op_illegal});
    t_wrap();
    t_sat();
    t_mul_move();
    t_misc();
    t_unpack();
    t_codes();
    results();
  end
endmodule
